// [bench/dbrd_host_model.sv]
// host-side model: reference clock source and rate pin driver
// assumes clk is the bench clock; pins change only after its rising edge
`timescale 1ns/1ps
module dbrd_host_model (
	// clock and control
	input wire logic clk,
	input wire logic ref_en,
	// pins toward the divider
	output logic ref_clock_in_a,
	output logic [3:0] rx_rate_code_bits,
	output logic rx_code_load,
	output logic [3:0] tx_rate_code_bits,
	output logic tx_code_load
);
	logic [1:0] ph;
	initial begin
		ph = 2'h0;
		ref_clock_in_a = 1'b0;
		rx_rate_code_bits = 4'h0;
		tx_rate_code_bits = 4'h0;
		rx_code_load = 1'b0;
		tx_code_load = 1'b0;
	end
	// reference of 8 clk period, stands still while disabled
	always @(posedge clk) begin
		if (ref_en) begin
			ph <= ph + 2'h1;
			if (ph == 2'h3)
				ref_clock_in_a <= !ref_clock_in_a;
		end
	end
	// code first, then a 4 clk strobe, code held well past its fall
	task automatic load(input bit ch, input logic [3:0] c, input bit pulse);
		@(posedge clk);
		if (ch)
			tx_rate_code_bits <= c;
		else
			rx_rate_code_bits <= c;
		@(posedge clk);
		if (ch)
			tx_code_load <= pulse;
		else
			rx_code_load <= pulse;
		repeat (4) @(posedge clk);
		rx_code_load <= 1'b0;
		tx_code_load <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
endmodule

// [bench/dual_baud_rate_divider_tb.sv]
// self-checking bench of the dual baud rate divider
// assumes the default 5.0688 MHz table and an 8 clk reference period
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end
module dual_baud_rate_divider_tb;
	import dbrd_pkg::*;
	logic clk, reset_n, ref_en, ref_clock_in_a, rx_code_load, tx_code_load, rx_baud_clk, tx_baud_clk;
	logic [3:0] rx_rate_code_bits, tx_rate_code_bits, s_axi_wstrb;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, lfsr;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int rx_m, tx_m;
	int div_tbl[16] = '{6336, 4224, 2880, 2355, 2112, 1056, 528, 264, 176, 158, 132, 88, 66, 44, 33, 16};
	int div_tbl2[16] = '{3456, 2304, 1571, 1285, 1152, 864, 576, 288, 144, 96, 86, 72, 48, 36, 18, 9};

	dbrd_host_model u_host (.clk(clk), .ref_en(ref_en), .ref_clock_in_a(ref_clock_in_a),
		.rx_rate_code_bits(rx_rate_code_bits), .rx_code_load(rx_code_load),
		.tx_rate_code_bits(tx_rate_code_bits), .tx_code_load(tx_code_load));
	dbrd_top u_dut (.clk(clk), .reset_n(reset_n), .ref_clock_in_a(ref_clock_in_a),
		.rx_rate_code_bits(rx_rate_code_bits), .rx_code_load(rx_code_load),
		.tx_rate_code_bits(tx_rate_code_bits), .tx_code_load(tx_code_load),
		.rx_baud_clk(rx_baud_clk), .tx_baud_clk(tx_baud_clk),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wait_lvl(input bit ch, input logic v, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((ch ? tx_baud_clk : rx_baud_clk) !== v && n < 4000);
	endtask

	// skips one whole period, then times the next high and low phases
	task automatic measure(input bit ch, input int n);
		int hi, lo, w;
		wait_lvl(ch, 1'b0, w);
		wait_lvl(ch, 1'b1, w);
		wait_lvl(ch, 1'b0, w);
		wait_lvl(ch, 1'b1, w);
		wait_lvl(ch, 1'b0, hi);
		wait_lvl(ch, 1'b1, lo);
		`CHK(hi, n / 2 * 8)
		`CHK(lo, (n - n / 2) * 8)
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_count++;
			stop_test();
		end
	end

	initial begin
		reset_n = 1'b0;
		ref_en = 1'b0;
		lfsr = 32'h5B6A;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		`CHK(rx_baud_clk, 1'b0)
		axi_rd(DBRD_ADDR_CTRL);
		`CHK(rd, 32'h3)
		axi_rd(DBRD_ADDR_INFO);
		`CHK(rd, 32'h10)
		axi_rd(DBRD_ADDR_STATUS);
		`CHK(rd[7:0], 8'h00)
		axi_rd(DBRD_ADDR_RX_DIV);
		`CHK(rd, 32'h2)
		$display("test reset done");
		// stopped channels take a new divisor at once
		axi_wr(DBRD_ADDR_CTRL, 32'h0);
		for (int i = 0; i < 16; i++) begin
			rx_m = i;
			tx_m = (i + 8) % 16;
			u_host.load(1'b0, rx_m[3:0], 1'b1);
			u_host.load(1'b1, tx_m[3:0], 1'b1);
			axi_rd(DBRD_ADDR_STATUS);
			`CHK(rd[7:0], {tx_m[3:0], rx_m[3:0]})
			axi_rd(DBRD_ADDR_RX_DIV);
			`CHK(rd, div_tbl[rx_m])
			axi_rd(DBRD_ADDR_TX_DIV);
			`CHK(rd, div_tbl[tx_m])
			`CHK(dbrd_lookup(DBRD_TBL_2M7648, rx_m[3:0]), div_tbl2[rx_m])
		end
		$display("test code table done");
		lfsr = lfsr_next(lfsr);
		u_host.load(1'b0, lfsr[3:0], 1'b0);
		u_host.load(1'b1, lfsr[7:4], 1'b0);
		axi_rd(DBRD_ADDR_STATUS);
		`CHK(rd[7:0], {tx_m[3:0], rx_m[3:0]})
		u_host.load(1'b1, 4'hE, 1'b1);
		axi_rd(DBRD_ADDR_STATUS);
		`CHK(rd[7:0], 8'hEF)
		$display("test strobe hold done");
		ref_en <= 1'b1;
		axi_wr(DBRD_ADDR_CTRL, 32'h3);
		measure(1'b0, 16);
		measure(1'b1, 33);
		u_host.load(1'b0, 4'hD, 1'b1);
		measure(1'b0, 44);
		$display("test waveform done");
		axi_wr(DBRD_ADDR_RX_DIV, lfsr);
		`CHK(rs, DBRD_RESP_OKAY)
		axi_rd(DBRD_ADDR_RX_DIV);
		`CHK(rd, 32'd44)
		axi_wr(8'h20, lfsr);
		`CHK(rs, DBRD_RESP_SLVERR)
		axi_rd(8'h24);
		`CHK(rs, DBRD_RESP_SLVERR)
		`CHK(rd, 32'h0)
		$display("test register access done");
		stop_test();
	end
endmodule

// [rtl/dbrd_channel.sv]
// one divider channel: counts reference ticks, drives a square wave
// assumes ref_tick is a one-cycle pulse per reference rising edge
`timescale 1ns/1ps
module dbrd_channel (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control
	input wire logic ref_tick,
	input wire logic run,
	input wire dbrd_pkg::dbrd_div_t divisor,
	// outputs
	output logic baud_out,
	output dbrd_pkg::dbrd_div_t div_used
);
	import dbrd_pkg::*;

	dbrd_div_t count;
	dbrd_div_t next_count;
	dbrd_div_t div_clamped;
	dbrd_div_t half;
	logic terminal;

	assign div_clamped = (divisor < DBRD_DIV_MIN) ? DBRD_DIV_MIN : divisor;
	assign terminal = (count >= div_used - 15'h0001);
	assign next_count = terminal ? 15'h0000 : count + 15'h0001;
	assign half = div_used >> 1;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 15'h0000;
		end else if (!run) begin
			count <= 15'h0000;
		end else if (ref_tick) begin
			count <= next_count;
		end
	end

	// new divisor only at wrap or while stopped, no runt pulses
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_used <= DBRD_DIV_MIN;
		end else if (!run || (ref_tick && terminal)) begin
			div_used <= div_clamped;
		end
	end

	// high for floor(n/2) ticks, then low; glitch-free flop output
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			baud_out <= 1'b0;
		end else if (!run) begin
			baud_out <= 1'b0;
		end else if (ref_tick) begin
			baud_out <= (next_count < half);
		end
	end

	property p_wrap;
		@(posedge clk) disable iff (!reset_n) run && ref_tick && terminal |=> count == 15'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap at terminal");

	property p_div_change;
		@(posedge clk) disable iff (!reset_n) $changed(div_used) && $past(run) |-> $past(ref_tick && terminal);
	endproperty
	a_div_change: assert property (p_div_change) else $error("divisor changed mid period");

	property p_div_min;
		@(posedge clk) disable iff (!reset_n) div_used >= DBRD_DIV_MIN;
	endproperty
	a_div_min: assert property (p_div_min) else $error("divisor below two");

	property p_high_phase;
		@(posedge clk) disable iff (!reset_n) run && ref_tick && terminal |=> baud_out;
	endproperty
	a_high_phase: assert property (p_high_phase) else $error("period did not start high");

	property p_low_phase;
		@(posedge clk) disable iff (!reset_n)
			run && ref_tick && !terminal && (count == half - 15'h0001) |=> !baud_out;
	endproperty
	a_low_phase: assert property (p_low_phase) else $error("low phase did not start at half");

	property p_idle;
		@(posedge clk) disable iff (!reset_n) !run |=> !baud_out && count == 15'h0000;
	endproperty
	a_idle: assert property (p_idle) else $error("stopped channel still running");
endmodule

// [rtl/dbrd_pkg.sv]
// constants, tables and types of the dual baud rate divider
// assumes one 40 MHz system clock; tables are chosen at build time
package dbrd_pkg;
	localparam int DBRD_CODE_W = 4;
	localparam int DBRD_DIV_W = 15;
	localparam int DBRD_ADDR_W = 8;
	localparam int DBRD_PINS = 11;
	localparam real DBRD_CLK_MHZ = 40.0;

	typedef logic [DBRD_DIV_W-1:0] dbrd_div_t;
	typedef dbrd_div_t dbrd_table_t [16];
	typedef enum logic [0:0] {
		DBRD_TBL_5M0688 = 1'b0,
		DBRD_TBL_2M7648 = 1'b1
	} dbrd_tbl_t;

	localparam dbrd_div_t DBRD_DIV_MIN = 15'h0002;
	localparam logic [3:0] DBRD_CODE_RST = 4'h0;
	localparam logic DBRD_PIN_IDLE = 1'b1;
	localparam logic [5:0] DBRD_MULT_16X = 6'h10;

	localparam dbrd_table_t DBRD_TABLE_5M0688 = '{
		15'h18C0, 15'h1080, 15'h0B40, 15'h0933, 15'h0840, 15'h0420, 15'h0210, 15'h0108,
		15'h00B0, 15'h009E, 15'h0084, 15'h0058, 15'h0042, 15'h002C, 15'h0021, 15'h0010};
	localparam dbrd_table_t DBRD_TABLE_2M7648 = '{
		15'h0D80, 15'h0900, 15'h0623, 15'h0505, 15'h0480, 15'h0360, 15'h0240, 15'h0120,
		15'h0090, 15'h0060, 15'h0056, 15'h0048, 15'h0030, 15'h0024, 15'h0012, 15'h0009};

	localparam logic [7:0] DBRD_ADDR_CTRL = 8'h00;
	localparam logic [7:0] DBRD_ADDR_STATUS = 8'h04;
	localparam logic [7:0] DBRD_ADDR_RX_DIV = 8'h08;
	localparam logic [7:0] DBRD_ADDR_TX_DIV = 8'h0C;
	localparam logic [7:0] DBRD_ADDR_INFO = 8'h10;

	localparam logic [1:0] DBRD_CTRL_RST = 2'h3;
	localparam int DBRD_CTRL_RX_RUN = 0;
	localparam int DBRD_CTRL_TX_RUN = 1;
	localparam int DBRD_ST_RX_CODE = 0;
	localparam int DBRD_ST_TX_CODE = 4;
	localparam int DBRD_ST_RX_OUT = 8;
	localparam int DBRD_ST_TX_OUT = 9;
	localparam int DBRD_ST_RX_LOAD = 10;
	localparam int DBRD_ST_TX_LOAD = 11;
	localparam int DBRD_INFO_MULT = 0;
	localparam int DBRD_INFO_TBL = 8;

	localparam logic [1:0] DBRD_RESP_OKAY = 2'h0;
	localparam logic [1:0] DBRD_RESP_SLVERR = 2'h2;

	function automatic dbrd_div_t dbrd_lookup(input dbrd_tbl_t tbl, input logic [3:0] code);
		if (tbl == DBRD_TBL_2M7648) begin
			return DBRD_TABLE_2M7648[code];
		end else begin
			return DBRD_TABLE_5M0688[code];
		end
	endfunction
endpackage

// [rtl/dbrd_top.sv]
// dual baud rate divider: pin-strobed rate codes, two divider channels,
// AXI4-Lite register slave for run control and status
// assumes the reference input is well below a quarter of clk
`timescale 1ns/1ps
module dbrd_top #(
	parameter dbrd_pkg::dbrd_tbl_t rate_table = dbrd_pkg::DBRD_TBL_5M0688
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// reference and rate pins
	input wire logic ref_clock_in_a,
	input wire logic [3:0] rx_rate_code_bits,
	input wire logic rx_code_load,
	input wire logic [3:0] tx_rate_code_bits,
	input wire logic tx_code_load,
	// baud outputs
	output logic rx_baud_clk,
	output logic tx_baud_clk,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import dbrd_pkg::*;

	logic [DBRD_PINS-1:0] pin_raw;
	logic [DBRD_PINS-1:0] sync1;
	logic [DBRD_PINS-1:0] sync2;
	logic [DBRD_PINS-1:0] sync3;
	logic [DBRD_PINS-1:0] pin_filt;
	logic ref_prev;
	logic ref_tick;
	logic rx_load_f;
	logic tx_load_f;
	logic [3:0] rx_code_f;
	logic [3:0] tx_code_f;
	logic [3:0] rx_code;
	logic [3:0] tx_code;
	dbrd_div_t rx_div;
	dbrd_div_t tx_div;
	dbrd_div_t rx_div_used;
	dbrd_div_t tx_div_used;
	logic [1:0] ctrl;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_fire;
	logic w_fire;
	logic have_aw;
	logic have_w;
	logic do_write;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// pin order: ref, strobes, receive code, transmit code
	assign pin_raw = {tx_rate_code_bits, rx_rate_code_bits, tx_code_load, rx_code_load, ref_clock_in_a};

	// three-stage synchroniser, value accepted when stages 2 and 3 agree
	genvar gi;
	generate
		for (gi = 0; gi < DBRD_PINS; gi++) begin : g_pin
			// reference and strobes reset low: no false tick or code load after reset
			localparam logic PIN_RST = (gi >= 3) ? DBRD_PIN_IDLE : !DBRD_PIN_IDLE;
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					sync1[gi] <= PIN_RST;
					sync2[gi] <= PIN_RST;
					sync3[gi] <= PIN_RST;
					pin_filt[gi] <= PIN_RST;
				end else begin
					sync1[gi] <= pin_raw[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi]) begin
						pin_filt[gi] <= sync3[gi];
					end
				end
			end
		end
	endgenerate

	assign rx_load_f = pin_filt[1];
	assign tx_load_f = pin_filt[2];
	assign rx_code_f = pin_filt[6:3];
	assign tx_code_f = pin_filt[10:7];

	// one tick per filtered reference rising edge, shared by both channels
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_prev <= 1'b0;
		end else begin
			ref_prev <= pin_filt[0];
		end
	end
	assign ref_tick = pin_filt[0] && !ref_prev;

	// rate registers, transparent while the strobe stays high
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_code <= DBRD_CODE_RST;
		end else if (rx_load_f) begin
			rx_code <= rx_code_f;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_code <= DBRD_CODE_RST;
		end else if (tx_load_f) begin
			tx_code <= tx_code_f;
		end
	end

	// fixed table picked by build parameter
	assign rx_div = dbrd_lookup(rate_table, rx_code);
	assign tx_div = dbrd_lookup(rate_table, tx_code);

	dbrd_channel u_rx_channel (
		.clk(clk),
		.reset_n(reset_n),
		.ref_tick(ref_tick),
		.run(ctrl[DBRD_CTRL_RX_RUN]),
		.divisor(rx_div),
		.baud_out(rx_baud_clk),
		.div_used(rx_div_used)
	);

	dbrd_channel u_tx_channel (
		.clk(clk),
		.reset_n(reset_n),
		.ref_tick(ref_tick),
		.run(ctrl[DBRD_CTRL_TX_RUN]),
		.divisor(tx_div),
		.baud_out(tx_baud_clk),
		.div_used(tx_div_used)
	);

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;
	assign have_aw = aw_held || aw_fire;
	assign have_w = w_held || w_fire;
	assign do_write = have_aw && have_w && !s_axi_bvalid;
	assign wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
	assign wr_data = w_held ? w_data_q : s_axi_wdata;
	assign wr_strb = w_held ? w_strb_q : s_axi_wstrb;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end else if (aw_fire) begin
			aw_held <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			w_held <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else if (do_write) begin
			w_held <= 1'b0;
		end else if (w_fire) begin
			w_held <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= DBRD_CTRL_RST;
		end else if (do_write && wr_addr == DBRD_ADDR_CTRL && wr_strb[0]) begin
			ctrl <= wr_data[1:0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= DBRD_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			case (wr_addr)
				DBRD_ADDR_CTRL, DBRD_ADDR_STATUS, DBRD_ADDR_RX_DIV, DBRD_ADDR_TX_DIV,
				DBRD_ADDR_INFO: begin
					s_axi_bresp <= DBRD_RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= DBRD_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read channel: one outstanding read, data one edge after address
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		next_rdata = 32'h00000000;
		next_rresp = DBRD_RESP_OKAY;
		case (s_axi_araddr)
			DBRD_ADDR_CTRL: begin
				next_rdata[1:0] = ctrl;
			end
			DBRD_ADDR_STATUS: begin
				next_rdata[DBRD_ST_RX_CODE +: 4] = rx_code;
				next_rdata[DBRD_ST_TX_CODE +: 4] = tx_code;
				next_rdata[DBRD_ST_RX_OUT] = rx_baud_clk;
				next_rdata[DBRD_ST_TX_OUT] = tx_baud_clk;
				next_rdata[DBRD_ST_RX_LOAD] = rx_load_f;
				next_rdata[DBRD_ST_TX_LOAD] = tx_load_f;
			end
			DBRD_ADDR_RX_DIV: begin
				next_rdata[DBRD_DIV_W-1:0] = rx_div_used;
			end
			DBRD_ADDR_TX_DIV: begin
				next_rdata[DBRD_DIV_W-1:0] = tx_div_used;
			end
			DBRD_ADDR_INFO: begin
				next_rdata[DBRD_INFO_MULT +: 6] = DBRD_MULT_16X;
				next_rdata[DBRD_INFO_TBL] = rate_table;
			end
			default: begin
				next_rresp = DBRD_RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= DBRD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	property p_rx_load;
		@(posedge clk) disable iff (!reset_n) rx_load_f |=> rx_code == $past(rx_code_f);
	endproperty
	a_rx_load: assert property (p_rx_load) else $error("receive code not loaded on strobe");

	property p_tx_load;
		@(posedge clk) disable iff (!reset_n) tx_load_f |=> tx_code == $past(tx_code_f);
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("transmit code not loaded on strobe");

	property p_rx_hold;
		@(posedge clk) disable iff (!reset_n) !rx_load_f |=> $stable(rx_code);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("receive code moved without strobe");

	property p_tx_hold;
		@(posedge clk) disable iff (!reset_n) !tx_load_f |=> $stable(tx_code);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("transmit code moved without strobe");

	property p_table_last;
		@(posedge clk) disable iff (!reset_n) rx_code == 4'hF |->
			rx_div == ((rate_table == DBRD_TBL_5M0688) ? 15'h0010 : 15'h0009);
	endproperty
	a_table_last: assert property (p_table_last) else $error("top code divisor wrong");

	property p_table_first;
		@(posedge clk) disable iff (!reset_n) tx_code == 4'h0 |->
			tx_div == ((rate_table == DBRD_TBL_5M0688) ? 15'h18C0 : 15'h0D80);
	endproperty
	a_table_first: assert property (p_table_first) else $error("code zero divisor wrong");

	property p_bresp;
		@(posedge clk) disable iff (!reset_n) do_write |=> s_axi_bvalid;
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response missing");

	property p_rresp;
		@(posedge clk) disable iff (!reset_n) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rresp: assert property (p_rresp) else $error("read response missing");

	property p_code_rst;
		@(posedge clk) disable iff (!reset_n) $rose(reset_n) |->
			rx_code == DBRD_CODE_RST && tx_code == DBRD_CODE_RST;
	endproperty
	a_code_rst: assert property (p_code_rst) else $error("rate code not cleared by reset");

	property p_no_false_load;
		@(posedge clk) disable iff (!reset_n) $rose(reset_n) |-> !rx_load_f && !tx_load_f;
	endproperty
	a_no_false_load: assert property (p_no_false_load) else $error("strobe seen high after reset");

	property p_ctrl_write;
		@(posedge clk) disable iff (!reset_n)
			do_write && wr_addr == DBRD_ADDR_CTRL && wr_strb[0] |=> ctrl == $past(wr_data[1:0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write not applied");
endmodule
